// ### logic/pfc_consts.vh
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
// ----------------------------------------------------------------------
// Command codes, status bit positions and bus timing for the flash host.
// ----------------------------------------------------------------------
// Final-cycle command codes.
`define PFC_CMD_SECTOR_ERASE 8'h50
`define PFC_CMD_BLOCK_ERASE 8'h30
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_SUSPEND 8'hb0
`define PFC_CMD_RESUME 8'h30
// Chip-erase final cycle address.
`define PFC_ADDR_CHIP_ERASE 22'h000555
// Status bit positions on the data bus.
`define PFC_BIT_POLL 7
`define PFC_BIT_ALT 6
`define PFC_BIT_ERASE_STATE 2
// User operation codes.
`define PFC_OP_READ 3'h0
`define PFC_OP_PROGRAM 3'h1
`define PFC_OP_SECTOR_ERASE 3'h2
`define PFC_OP_BLOCK_ERASE 3'h3
`define PFC_OP_CHIP_ERASE 3'h4
`define PFC_OP_SUSPEND 3'h5
`define PFC_OP_RESUME 3'h6
// Bus phase length in core cycles (40 ns each, 80 ns per phase).
`define PFC_PHASE_NS 80
`define PFC_CLK_NS 40
`define PFC_PHASE_CYC ((`PFC_PHASE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
// Settle time before all data bits are valid after polling completes.
`define PFC_SETTLE_NS 1000
`define PFC_SETTLE_CYC ((`PFC_SETTLE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
// Longest program time, used as a poll timeout.
`define PFC_PROG_MAX_NS 10000
`define PFC_PROG_MAX_CYC (`PFC_PROG_MAX_NS / `PFC_CLK_NS)
// Suspend settle time before reads are trusted.
`define PFC_SUSPEND_NS 20000
`define PFC_SUSPEND_CYC (`PFC_SUSPEND_NS / `PFC_CLK_NS)
`endif

// ### logic/pfc_sync.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Three-stage input synchroniser; the output changes only when the
// second and third stages agree, so a single-stage glitch is dropped.
// ----------------------------------------------------------------------
module pfc_sync #(
  parameter WIDTH = 16
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Asynchronous input and filtered result.
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1; // Read only by stage2.
  reg [WIDTH-1:0] stage2; // Second stage.
  reg [WIDTH-1:0] stage3; // Third stage.
  integer i;

  // Shift, then update each bit where the two late stages agree.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          dout[i] <= stage3[i];
        end
      end
    end
  end
endmodule // pfc_sync

// ### logic/pfc_host.v
`timescale 1ns/1ps
// Function
// - Host writes with strobe low, select low.
// - Program: three unlock cycles then word.
// - Host keeps write protect static during sequences.
// - Sector erase: six cycles ending 50H.
// - Block erase: six cycles ending 30H.
// - Host rereads twice once the alternating bit stops flipping.
`include "pfc_consts.vh"
module pfc_host #(
  parameter ADDR_W = 22,
  parameter UNLOCK_ADDR1 = 22'h000555, // Unlock values are parameters.
  parameter UNLOCK_ADDR2 = 22'h0002aa,
  parameter [7:0] UNLOCK_DATA1 = 8'haa,
  parameter [7:0] UNLOCK_DATA2 = 8'h55,
  parameter [7:0] PROG_SETUP = 8'ha0,
  parameter [7:0] ERASE_SETUP = 8'h80,
  parameter POLL_LIMIT = `PFC_PROG_MAX_CYC
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // User command port.
  input wire req,
  input wire [2:0] op,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  input wire protect,
  output reg busy,
  output reg done,
  output reg fail,
  output reg [15:0] rdata,
  // Flash pins.
  output reg [ADDR_W-1:0] fl_addr,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n,
  output reg fl_wp_n,
  input wire [15:0] fl_dq_in,
  output reg [15:0] fl_dq_out,
  output reg fl_dq_oe
);
  // ----------------------------------------------------------------------
  // States and locals.
  // ----------------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_WSET = 3'h1; // Address stable, strobe low.
  localparam S_WREL = 3'h2; // Strobe high again.
  localparam S_RSET = 3'h3; // Gate low, waiting for data.
  localparam S_RCAP = 3'h4; // Data sampled.
  localparam S_SETTLE = 3'h5; // Waiting for all bits to be valid.
  localparam S_GAP = 3'h6; // Gate high between two polls.
  localparam [7:0] PHASE = `PFC_PHASE_CYC;
  localparam [15:0] SETTLE = `PFC_SETTLE_CYC;
  localparam [15:0] POLL_MAX = POLL_LIMIT; // Cycles, not polls.
  localparam [15:0] SUSPEND_WAIT = `PFC_SUSPEND_CYC;

  reg [2:0] state; // Bus sequencer state.
  reg [7:0] phase_cnt; // Cycles left in the current phase.
  reg [2:0] cyc_idx; // Write cycle within the command.
  reg [2:0] cyc_total; // Write cycles in the command.
  reg [2:0] cur_op; // Operation in flight.
  reg [ADDR_W-1:0] cur_addr; // Target address.
  reg [15:0] cur_data; // Program data.
  reg polling; // Reads are status polls, not a plain read.
  reg [1:0] reread; // Confirming reads still owed.
  reg [15:0] prev_rd; // Previous poll value.
  reg [15:0] wait_cnt; // Poll timeout or settle counter.
  wire [15:0] dq_sync; // Filtered data bus.

  pfc_sync #(.WIDTH(16)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(fl_dq_in),
    .dout(dq_sync)
  );

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Address of write cycle n of op; the last carries the target, except for chip erase (000555H).
  function [ADDR_W-1:0] cyc_addr;
    input [2:0] o;
    input [2:0] n;
    input [2:0] tot;
    input [ADDR_W-1:0] a;
    begin
      if (n == tot - 3'h1) begin
        if (o == `PFC_OP_CHIP_ERASE)
          cyc_addr = `PFC_ADDR_CHIP_ERASE;
        else
          cyc_addr = a; // Sector/block bits select the target.
      end else if (n == 3'h1 || n == 3'h4) begin
        cyc_addr = UNLOCK_ADDR2;
      end else begin
        cyc_addr = UNLOCK_ADDR1;
      end
    end
  endfunction

  // Data of write cycle n of op.
  function [15:0] cyc_data;
    input [2:0] o;
    input [2:0] n;
    input [2:0] tot;
    input [15:0] d;
    begin
      if (n == tot - 3'h1) begin
        case (o)
          `PFC_OP_PROGRAM: cyc_data = d;
          `PFC_OP_SECTOR_ERASE: cyc_data = {8'h00, `PFC_CMD_SECTOR_ERASE};
          `PFC_OP_BLOCK_ERASE: cyc_data = {8'h00, `PFC_CMD_BLOCK_ERASE};
          `PFC_OP_CHIP_ERASE: cyc_data = {8'h00, `PFC_CMD_CHIP_ERASE};
          `PFC_OP_SUSPEND: cyc_data = {8'h00, `PFC_CMD_SUSPEND};
          `PFC_OP_RESUME: cyc_data = {8'h00, `PFC_CMD_RESUME};
          default: cyc_data = 16'h0000;
        endcase
      end else if (n == 3'h1 || n == 3'h4) begin
        cyc_data = {8'h00, UNLOCK_DATA2};
      end else if (n == 3'h2) begin
        cyc_data = {8'h00, (o == `PFC_OP_PROGRAM) ? PROG_SETUP : ERASE_SETUP};
      end else begin
        cyc_data = {8'h00, UNLOCK_DATA1};
      end
    end
  endfunction

  // Write cycles needed by each operation.
  function [2:0] op_cycles;
    input [2:0] o;
    begin
      case (o)
        `PFC_OP_PROGRAM: op_cycles = 3'h4;
        `PFC_OP_SECTOR_ERASE: op_cycles = 3'h6;
        `PFC_OP_BLOCK_ERASE: op_cycles = 3'h6;
        `PFC_OP_CHIP_ERASE: op_cycles = 3'h6;
        `PFC_OP_SUSPEND: op_cycles = 3'h1;
        `PFC_OP_RESUME: op_cycles = 3'h1;
        default: op_cycles = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus sequencer.
  // ----------------------------------------------------------------------
  // Writes hold select and strobe low together; address is set on the
  // same edge as the falling strobe and data held past the rising edge.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      phase_cnt <= 8'h00;
      cyc_idx <= 3'h0;
      cyc_total <= 3'h0;
      cur_op <= 3'h0;
      cur_addr <= {ADDR_W{1'b0}};
      cur_data <= 16'h0000;
      polling <= 1'b0;
      reread <= 2'h0;
      prev_rd <= 16'h0000;
      wait_cnt <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= {ADDR_W{1'b0}};
      fl_ce_n <= 1'b1; // Deselected: standby power.
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_wp_n <= 1'b1;
      fl_dq_out <= 16'h0000;
      fl_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      // The program limit runs on clock cycles, whatever a poll costs.
      if (polling && wait_cnt != 16'h0000 && state != S_SETTLE) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
      case (state)
        S_IDLE: begin
          fl_ce_n <= 1'b1;
          fl_oe_n <= 1'b1;
          fl_we_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          if (req) begin
            busy <= 1'b1;
            fail <= 1'b0;
            cur_op <= op;
            cur_addr <= addr;
            cur_data <= wdata;
            fl_wp_n <= ~protect; // Latched once per command.
            cyc_idx <= 3'h0;
            cyc_total <= op_cycles(op);
            phase_cnt <= PHASE;
            polling <= 1'b0;
            reread <= 2'h0;
            fl_addr <= (op == `PFC_OP_READ) ? addr
                     : cyc_addr(op, 3'h0, op_cycles(op), addr);
            fl_dq_out <= cyc_data(op, 3'h0, op_cycles(op), wdata);
            fl_ce_n <= 1'b0;
            if (op == `PFC_OP_READ) begin
              fl_oe_n <= 1'b0; // New address wakes device.
              state <= S_RSET;
            end else begin
              fl_dq_oe <= 1'b1;
              fl_we_n <= 1'b0;
              state <= S_WSET;
            end
          end
        end
        S_WSET: begin
          if (phase_cnt <= 8'h01) begin
            fl_we_n <= 1'b1; // Device latches data here.
            phase_cnt <= PHASE;
            state <= S_WREL;
          end else begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        S_WREL: begin
          if (phase_cnt <= 8'h01) begin
            phase_cnt <= PHASE;
            if (cyc_idx == cyc_total - 3'h1) begin
              fl_dq_oe <= 1'b0;
              if (cur_op == `PFC_OP_SUSPEND) begin
                wait_cnt <= SUSPEND_WAIT; // Wait for read mode.
                state <= S_SETTLE;
                fl_ce_n <= 1'b1;
              end else if (cur_op == `PFC_OP_RESUME) begin
                busy <= 1'b0;
                done <= 1'b1;
                state <= S_IDLE;
              end else begin
                // Status is valid after the final rise.
                polling <= 1'b1; // Reads now give status only.
                wait_cnt <= POLL_MAX;
                fl_addr <= cur_addr; // Status needs a valid address.
                fl_oe_n <= 1'b0;
                state <= S_RSET;
              end
            end else begin
              cyc_idx <= cyc_idx + 3'h1;
              fl_addr <= cyc_addr(cur_op, cyc_idx + 3'h1, cyc_total,
                                  cur_addr);
              fl_dq_out <= cyc_data(cur_op, cyc_idx + 3'h1, cyc_total,
                                    cur_data);
              fl_we_n <= 1'b0;
              state <= S_WSET;
            end
          end else begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        S_RSET: begin
          // Extra cycles cover the three-stage input filter.
          if (phase_cnt == 8'h00) begin
            phase_cnt <= 8'h04; // Filter output lags the pins by four.
            state <= S_RCAP;
          end else begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        S_RCAP: begin
          if (phase_cnt > 8'h01) begin
            phase_cnt <= phase_cnt - 8'h01;
          end else begin
            fl_oe_n <= 1'b1; // Close the gate so every poll is a new read.
            phase_cnt <= PHASE;
            if (!polling) begin
              rdata <= dq_sync;
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end else if (reread == 2'h0 &&
                         dq_sync[`PFC_BIT_ALT] != prev_rd[`PFC_BIT_ALT]) begin
              // Still busy: alternating bit flips.
              prev_rd <= dq_sync;
              if (wait_cnt == 16'h0000 && cur_op == `PFC_OP_PROGRAM) begin
                fail <= 1'b1; // Overran the longest program time.
                busy <= 1'b0;
                done <= 1'b1;
                state <= S_IDLE;
              end else begin
                state <= S_GAP;
              end
            end else if (reread == 2'h0) begin
              // Alternating bit steady; confirm twice.
              prev_rd <= dq_sync;
              reread <= 2'h2;
              state <= S_GAP;
            end else begin
              if (dq_sync[`PFC_BIT_ALT] != prev_rd[`PFC_BIT_ALT]) begin
                reread <= 2'h0; // Toggling resumed: still busy, keep polling.
              end else begin
                reread <= reread - 2'h1;
              end
              prev_rd <= dq_sync;
              if (reread == 2'h1 &&
                  dq_sync[`PFC_BIT_ALT] == prev_rd[`PFC_BIT_ALT]) begin
                // Let the other bits settle.
                // A refused or protected command also ends here.
                wait_cnt <= SETTLE;
                state <= S_SETTLE;
              end else begin
                state <= S_GAP;
              end
            end
          end
        end
        S_GAP: begin
          // The gate stays high a phase, so the device sees a new read.
          if (phase_cnt <= 8'h01) begin
            fl_oe_n <= 1'b0;
            phase_cnt <= PHASE;
            state <= S_RSET;
          end else begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        S_SETTLE: begin
          if (wait_cnt <= 16'h0001) begin
            if (polling) begin
              // Fresh read of the target once every bit is valid.
              polling <= 1'b0;
              fl_oe_n <= 1'b0;
              phase_cnt <= PHASE;
              state <= S_RSET;
            end else begin
              // Suspend wait over: the device reads again.
              fl_ce_n <= 1'b1;
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // pfc_host

// ### sim/pfc_host_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Pin protocol checks on the flash host.
// ----------------------------------------------------------------------
module pfc_host_checker #(
  parameter ADDR_W = 22
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // User side.
  input wire req,
  input wire busy,
  input wire done,
  // Flash pins.
  input wire [ADDR_W-1:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  input wire fl_wp_n,
  input wire [15:0] fl_dq_out,
  input wire fl_dq_oe
);
  // All checks share the core clock and sleep during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  we_with_sel_a: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("Write strobe low without chip select.");
  we_not_oe_a: assert property (!fl_we_n |-> fl_oe_n)
    else $error("Write strobe and output gate low together.");
  no_fight_a: assert property (fl_dq_oe |-> fl_oe_n)
    else $error("Host drives data while the gate is open.");
  oe_with_sel_a: assert property (!fl_oe_n |-> !fl_ce_n)
    else $error("Output gate low without chip select.");
  we_pulse_a: assert property ($fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n)
    else $error("Write strobe low phase is not two cycles.");
  wr_drive_a: assert property (!fl_we_n |-> fl_dq_oe)
    else $error("Strobe low while data is not driven.");
  // Data must still stand when the strobe rises, or the latch misses it.
  wr_hold_a: assert property ($rose(fl_we_n) |->
      $stable(fl_dq_out) && $stable(fl_addr))
    else $error("Address or data moved with the strobe edge.");
  wp_static_a: assert property (busy && $past(busy, 2) |-> $stable(fl_wp_n))
    else $error("Write protect changed during a sequence.");
  take_req_a: assert property (req && !busy |=> busy)
    else $error("Request not taken while idle.");
  done_pulse_a: assert property (done |-> !busy ##1 !done)
    else $error("Done is not a single idle pulse.");
  oe_gap_a: assert property ($rose(fl_oe_n) |=> fl_oe_n)
    else $error("Output gate reopened without a gap.");
endmodule // pfc_host_checker

bind pfc_host pfc_host_checker #(.ADDR_W(ADDR_W)) u_pfc_host_checker (
  .core_clk(core_clk), .rst_n(rst_n), .req(req), .busy(busy),
  .done(done), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .fl_wp_n(fl_wp_n), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe)
);

// ### sim/pfc_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Behavioural flash device answering the host's pin cycles.
// ----------------------------------------------------------------------
module pfc_flash_model #(
  parameter [10:0] UA1 = 11'h555, UA2 = 11'h2aa, // Unlock steps.
  parameter [7:0] UD1 = 8'haa, UD2 = 8'h55, PS = 8'ha0, ES = 8'h80
) (
  // Pins from the host.
  input wire [21:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  input wire fl_wp_n,
  input wire [15:0] fl_dq_out,
  input wire fl_dq_oe,
  // Resolved data bus.
  output logic [15:0] dq
);
  logic [15:0] mem [int]; // Unwritten words read as all ones.
  logic [21:0] la, ea, em; // Latched, erase and region mask addresses.
  logic [15:0] pd; // Word being programmed.
  int st, left; // Command step and remaining busy time.
  int prog_ns = 2000; // Bench may stretch this to break the time limit.
  int erase_ns = 4000; // Short stand-in for real erase times.
  bit act, run, ers, susp, tog, tog2, settle, flip;

  // Address is taken when the later of strobe and select falls.
  always @(negedge fl_we_n or negedge fl_ce_n) begin
    #1; // Strobe, select and address may all move on one host edge.
    if (!fl_we_n && !fl_ce_n) begin
      la = fl_addr;
      act = 1;
    end
  end
  // Data is taken when the earlier of the two rises.
  always @(posedge fl_we_n or posedge fl_ce_n)
    if (act) begin
      act = 0;
      wr(la, fl_dq_out);
    end

  // Decode one completed write cycle.
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    bit u1, u2, pr;
    u1 = a[10:0] == UA1;
    u2 = a[10:0] == UA2;
    pr = !fl_wp_n && a < 22'h8000; // Bottom boot block locked.
    if (run && !susp) begin // Busy: only suspend counts.
      if (ers && em != 0 && d[7:0] == 8'hb0) susp = 1;
    end else if (susp) begin
      if (d[7:0] == 8'h30) susp = 0;
    end else case (st)
      0, 4: st = (u1 && d[7:0] == UD1) ? st + 1 : 0;
      1, 5: st = (u2 && d[7:0] == UD2) ? st + 1 : 0;
      2: st = !u1 ? 0 : d[7:0] == PS ? 3 : d[7:0] == ES ? 4 : 0;
      3: begin
        st = 0;
        if (!pr) fork go(0, a, 0, d); join_none
      end
      6: begin
        st = 0;
        if (d[7:0] == 8'h50 && !pr) fork go(1, a, ~22'h7ff, d); join_none
        if (d[7:0] == 8'h30 && !pr) fork go(1, a, ~22'h7fff, d); join_none
        if (d[7:0] == 8'h10 && u1 && fl_wp_n) fork go(1, a, 0, d); join_none
      end
      default: st = 0;
    endcase
  endtask

  // Internal operation; time stands still while suspended.
  task automatic go(input bit e, input logic [21:0] a, m,
                    input logic [15:0] d);
    run = 1;
    ers = e;
    ea = a;
    em = m;
    pd = d;
    left = e ? erase_ns : prog_ns;
    while (left > 0) begin
      #100;
      if (!susp) left -= 100;
    end
    if (e) foreach (mem[k]) begin
      if ((k & m) == (a & m)) mem[k] = 16'hffff;
    end else mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d;
    run = 0;
    ers = 0;
    settle = !e;
    #1000 settle = 0; // All bits but the poll and alternating bits lag.
  endtask

  // Every read start flips both toggle bits.
  always @(negedge fl_oe_n) begin
    #1; // Select may fall on the same host edge as the gate.
    if (!fl_ce_n) {tog, tog2} = ~{tog, tog2};
  end

  // Word seen on a read of the given address.
  function automatic logic [15:0] rd(input logic [21:0] ad);
    logic [15:0] v;
    v = mem.exists(ad) ? mem[ad] : 16'hffff;
    if (susp && (ad & em) == (ea & em))
      return {8'h00, 2'b11, 3'b000, tog2, 2'b00};
    if (susp) return v;
    if (run && ers) return {8'h00, 1'b0, tog, 3'b000, tog2, 2'b00};
    if (run) return {8'h00, ~pd[7], tog, 6'h00};
    if (settle && ad == ea) return v ^ 16'hff3f;
    return v;
  endfunction

  // Bus level; a released bus shows a changing pattern, never old data.
  always #4 begin
    flip = ~flip;
    dq = fl_dq_oe ? fl_dq_out : (!fl_ce_n && !fl_oe_n) ? rd(fl_addr)
       : {8{flip, ~flip}};
  end
endmodule // pfc_flash_model

// ### sim/pfc_host_tb.sv
`timescale 1ns/1ps
`include "pfc_consts.vh"
// ----------------------------------------------------------------------
// Bench driving the flash host against the device model.
// ----------------------------------------------------------------------
module pfc_host_tb;
  logic core_clk = 0;
  logic rst_n = 0;
  logic req = 0;
  logic protect = 0;
  logic [2:0] op = 0;
  logic [21:0] addr = 0;
  logic [15:0] wdata = 0;
  wire busy, done, fail, fl_ce_n, fl_oe_n, fl_we_n, fl_wp_n, fl_dq_oe;
  wire [21:0] fl_addr;
  wire [15:0] rdata, fl_dq_out, fl_dq_in;
  logic [18:0] expq [$]; // Notes: {check data, check fail, fail, data}.
  logic [18:0] e;
  logic [21:0] pa [5];
  logic [15:0] pd [5];
  logic [15:0] r1, r2;
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  always #20 core_clk = ~core_clk;

  pfc_host u_pfc_host (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .protect(protect), .busy(busy), .done(done),
    .fail(fail), .rdata(rdata), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_wp_n(fl_wp_n),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe)
  );
  pfc_flash_model u_pfc_flash_model (
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_wp_n(fl_wp_n), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .dq(fl_dq_in)
  );

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Issue one operation, note its outcome, wait for the done pulse.
  task automatic run_op(input logic [2:0] o, input logic [21:0] a,
                        input logic [15:0] d, input bit p,
                        input logic [18:0] x);
    expq.push_back(x);
    @(posedge core_clk);
    req <= 1;
    op <= o;
    addr <= a;
    wdata <= d;
    protect <= p;
    @(posedge core_clk);
    req <= 0;
    do @(negedge core_clk); while (done !== 1'b1);
  endtask

  task automatic rdchk(input logic [21:0] a, input logic [15:0] d);
    run_op(`PFC_OP_READ, a, 0, 0, {3'b100, d});
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Results are settled by the falling edge; take the oldest note.
  always @(negedge core_clk)
    if (done === 1'b1) begin
      e = expq.pop_front();
      if (e[18]) chk(rdata, e[15:0]);
      if (e[17]) chk({15'h0000, fail}, {15'h0000, e[16]});
    end

  // A hang is cut short well past the expected run length.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    r1 = $urandom(39148);
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    rdchk(22'h12345, 16'hffff);
    $display("Test read of blank word ended.");
    // Five words in distinct sectors; the last one in the next block.
    for (int i = 0; i < 5; i++) begin
      pa[i] = 22'h10000 + i * 22'h2000 + ($urandom % 22'h800);
      pd[i] = $urandom;
      run_op(`PFC_OP_PROGRAM, pa[i], pd[i], 0, {3'b110, pd[i]});
      rdchk(pa[i], pd[i]);
    end
    $display("Test program ended.");
    run_op(`PFC_OP_SECTOR_ERASE, pa[0], 0, 0, {3'b100, 16'hffff});
    rdchk(pa[0], 16'hffff);
    rdchk(pa[1], pd[1]);
    run_op(`PFC_OP_BLOCK_ERASE, pa[1], 0, 0, {3'b100, 16'hffff});
    rdchk(pa[2], 16'hffff);
    rdchk(pa[4], pd[4]);
    $display("Test sector and block erase ended.");
    // The boot block refuses changes while protect is asked for.
    run_op(`PFC_OP_PROGRAM, 22'h00100, 16'h1234, 1, 0);
    rdchk(22'h00100, 16'hffff);
    run_op(`PFC_OP_PROGRAM, 22'h00100, 16'h1234, 0, {3'b110, 16'h1234});
    run_op(`PFC_OP_SECTOR_ERASE, 22'h00100, 0, 1, 0);
    run_op(`PFC_OP_CHIP_ERASE, 0, 0, 1, 0);
    rdchk(22'h00100, 16'h1234);
    run_op(`PFC_OP_CHIP_ERASE, 0, 0, 0, {3'b100, 16'hffff});
    rdchk(22'h00100, 16'hffff);
    rdchk(pa[4], 16'hffff);
    $display("Test protect and chip erase ended.");
    // A device slower than the program limit must be flagged.
    u_pfc_flash_model.prog_ns = 20000;
    run_op(`PFC_OP_PROGRAM, 22'h20000, 16'h0f0f, 0, {3'b011, 16'h0000});
    u_pfc_flash_model.prog_ns = 2000;
    repeat (500) @(posedge core_clk);
    $display("Test slow program ended.");
    // Long erase, then suspend, look around, and resume.
    u_pfc_flash_model.erase_ns = 100000;
    // The host is reset mid-poll; the device keeps erasing meanwhile.
    @(posedge core_clk);
    req <= 1;
    op <= `PFC_OP_SECTOR_ERASE;
    addr <= 22'h30000;
    @(posedge core_clk);
    req <= 0;
    repeat (200) @(posedge core_clk);
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(negedge core_clk);
    chk({13'h0000, busy, fl_oe_n, fl_ce_n}, 16'h0003);
    run_op(`PFC_OP_SUSPEND, 22'h30000, 0, 0, 0);
    run_op(`PFC_OP_READ, 22'h30010, 0, 0, 0);
    r1 = rdata;
    run_op(`PFC_OP_READ, 22'h30010, 0, 0, 0);
    r2 = rdata;
    chk(r1 ^ r2, 16'h0004);
    chk(r2 & 16'h00c0, 16'h00c0);
    rdchk(22'h38000, 16'hffff);
    run_op(`PFC_OP_RESUME, 22'h00000, 0, 0, 0);
    run_op(`PFC_OP_READ, 22'h30010, 0, 0, 0);
    r1 = rdata;
    run_op(`PFC_OP_READ, 22'h30010, 0, 0, 0);
    chk(r1 & 16'h0080, 16'h0000);
    chk((r1 ^ rdata) & 16'h0040, 16'h0040);
    $display("Test suspend and resume ended.");
    print_verdict();
  end
endmodule // pfc_host_tb
